// File: frt_pkg.sv
// frt_pkg: constants, field layout and types of the free running timer.
// assumes a 100 MHz system clock and a 32-bit classic wishbone host.
package frt_pkg;
    // clock and pulse timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int WD_PULSE_NS = 40;
    localparam int RST_PULSE_CYC =
        (WD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // divider chain
    localparam int CHAIN_W = 17;
    localparam int PACC_GATE_LOG2 = 6;
    localparam int PRESC_LOG2_DIV1 = 0;
    localparam int PRESC_LOG2_DIV4 = 2;
    localparam int PRESC_LOG2_DIV8 = 3;
    localparam int PRESC_LOG2_DIV16 = 4;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_EDGE = 8'h08;
    localparam logic [7:0] OFF_OC_ACT = 8'h0C;
    localparam logic [7:0] OFF_OC1 = 8'h10;
    localparam logic [7:0] OFF_FLAGS = 8'h14;
    localparam logic [7:0] OFF_IRQ_EN = 8'h18;
    localparam logic [7:0] OFF_PORT = 8'h1C;
    localparam logic [7:0] OFF_DIR = 8'h20;
    localparam logic [7:0] OFF_PACC = 8'h24;
    localparam logic [7:0] OFF_WDOG = 8'h28;
    localparam logic [7:0] OFF_CHAN = 8'h40;
    localparam logic [7:0] OFF_CHAN_END = 8'h5C;
    // control register fields
    localparam int CTRL_W = 9;
    localparam int CTRL_PRESC = 0;
    localparam int CTRL_RTI = 2;
    localparam int CTRL_PACC_EN = 4;
    localparam int CTRL_PACC_GATED = 5;
    localparam int CTRL_PACC_POL = 6;
    localparam int CTRL_CH4_CAPT = 7;
    localparam int CTRL_WD_EN = 8;
    // flag bits, bits 7:0 are the channel events
    localparam int FLG_W = 12;
    localparam int FLG_OVF = 8;
    localparam int FLG_RTI = 9;
    localparam int FLG_PACC_OVF = 10;
    localparam int FLG_PACC_EDGE = 11;
    // channels and pins
    localparam int CH_N = 8;
    localparam int CH_SHARED = 3;
    localparam int CH_OC1 = 4;
    localparam int OC1_W = 10;
    localparam int OC1_DATA = 5;
    localparam int PIN_N = 8;
    localparam int PIN_OC_LOW = 3;
    localparam int PIN_TOP = 7;
    localparam int EDGE_RISE = 0;
    localparam int EDGE_FALL = 1;
    // reset values and keys
    localparam logic [15:0] CMP_RST = 16'hFFFF;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [7:0] PACC_MAX = 8'hFF;
    localparam logic [7:0] WD_KEY_ARM = 8'h55;
    localparam logic [7:0] WD_KEY_FIRE = 8'hAA;
    // compare pin actions
    localparam logic [1:0] OC_NONE = 2'h0;
    localparam logic [1:0] OC_TOGGLE = 2'h1;
    localparam logic [1:0] OC_CLEAR = 2'h2;
    localparam logic [1:0] OC_SET = 2'h3;

    typedef enum logic {WD_IDLE, WD_ARMED} frt_wd_e;

    function automatic int presc_log2(input logic [1:0] sel);
        case (sel)
            2'h0: return PRESC_LOG2_DIV1;
            2'h1: return PRESC_LOG2_DIV4;
            2'h2: return PRESC_LOG2_DIV8;
            default: return PRESC_LOG2_DIV16;
        endcase
    endfunction : presc_log2
endpackage : frt_pkg

// File: frt_timer.sv
// frt_timer: prescaled 16-bit free running counter with capture/compare,
// pulse accumulator, periodic interrupt and watchdog, wishbone registers.
// assumes synchronous wishbone master on CLK_SYS_I, async port A pins.
// Functional notes
// RQ1: prescaler divides by 1, 4, 8, 16 for select codes 00..11.
// RQ2: main counter is 16 bits, counts up from zero after reset.
// RQ3: at all-ones counter wraps to zero, sets overflow, keeps counting.
// RQ4: software cannot reset, load, stop or interrupt the main counter.
// RQ5: three capture, four compare, one shared channel, each 16-bit.
// RQ6: every timer event has its own enable and interrupt line.
// RQ7: chain taps clock accumulator, periodic interrupt and watchdog.
// RQ8: event mode counts each selected edge on the accumulator input.
// RQ9: gated mode counts internal clock while input holds chosen level.
// RQ10: periodic interrupt at one of four selectable rates.
// RQ11: watchdog clocked at bus clock over 2^15, times out unless served.
// RQ12: watchdog timeout drives the reset pin low.
// RQ13: four low pins have edge detectors with edge selection.
// RQ14: low four pin levels always readable through port data.
// RQ15: compare-owned pins ignore general purpose writes.
// RQ16: compare channels two to five each own one port pin.
// RQ17: compare channel one may drive any of the five upper pins.
// RQ18: top pin is gpio, accumulator input or channel one output.
// RQ19: captures take the stable count, not the one being incremented.
// RQ20: counter steps exactly one per prescaler tick.
`timescale 1ns/100ps
module frt_timer #(
    parameter int WD_DIV_LOG2 = 15,
    parameter int RTI_BASE_LOG2 = 13,
    parameter int WD_TIMEOUT_TICKS = 8
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // port a pins
    input wire logic [frt_pkg::PIN_N-1:0] PA_I,
    output logic [frt_pkg::PIN_N-1:0] PA_O,
    output logic [frt_pkg::PIN_N-1:0] PA_OE_O,
    // open drain reset pin
    output logic RST_PIN_O,
    output logic RST_PIN_OE_O,
    // one interrupt line per event
    output logic [frt_pkg::FLG_W-1:0] IRQ_O
);
    import frt_pkg::*;

    if (WD_DIV_LOG2 < 1 || WD_DIV_LOG2 > CHAIN_W)
        $error("frt_timer: WD_DIV_LOG2 out of range");
    if (RTI_BASE_LOG2 < 1 || RTI_BASE_LOG2 + 3 > CHAIN_W)
        $error("frt_timer: RTI_BASE_LOG2 out of range");
    if (WD_TIMEOUT_TICKS < 1 || WD_TIMEOUT_TICKS > 15)
        $error("frt_timer: WD_TIMEOUT_TICKS out of range");

    localparam logic [3:0] WD_LAST = 4'(WD_TIMEOUT_TICKS - 1);
    localparam logic [2:0] RST_CNT_LOAD = 3'(RST_PULSE_CYC - 1);

    typedef struct packed {
        logic [PIN_N-1:0] s1;
        logic [PIN_N-1:0] s2;
        logic [PIN_N-1:0] s3;
        logic [PIN_N-1:0] lvl;
        logic ack;
        logic [31:0] rdat;
        logic [CHAIN_W-1:0] chain;
        logic [15:0] cnt;
        logic [CTRL_W-1:0] ctrl;
        logic [7:0] edge_cfg;
        logic [7:0] oc_act;
        logic [OC1_W-1:0] oc1_ctl;
        logic [FLG_W-1:0] flags;
        logic [FLG_W-1:0] irq_en;
        logic [PIN_N-1:0] gp;
        logic [PIN_N-1:0] dir;
        logic [7:0] pacc;
        logic [CH_N-1:0][15:0] ch;
        logic [PIN_N-1:0] oc_lvl;
        logic [PIN_N-1:0] pa_out;
        logic [PIN_N-1:0] pa_oe;
        frt_wd_e wd_st;
        logic [3:0] wd_cnt;
        logic [2:0] rst_cnt;
        logic rst_drv;
    } frt_state_s;

    frt_state_s state_reg;
    frt_state_s state_next;

    // true when the low n bits of the chain are all ones
    function automatic logic low_ones(input logic [CHAIN_W-1:0] v,
                                      input int n);
        logic [CHAIN_W-1:0] m;
        m = CHAIN_W'((64'h0000_0000_0000_0001 << n) - 1);
        return &(v | ~m);
    endfunction : low_ones

    // byte lane merge of a write into a register
    function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                r[8*b +: 8] = d[8*b +: 8];
        end
        return r;
    endfunction : wb_merge

    logic tick;
    logic wd_tick;
    logic wd_timeout;
    logic pacc_inc;
    logic pacc_edge;
    logic req;
    logic wr;
    logic [15:0] cnt_inc;
    logic [PIN_N-1:0] rise;
    logic [PIN_N-1:0] fall;
    logic [PIN_N-1:0] own;
    logic [CH_N-1:0] match;
    logic [CH_N-1:0] cap_hit;
    logic [FLG_W-1:0] ev;
    logic [FLG_W-1:0] clr;
    logic [31:0] mw;
    logic [1:0] cfg;
    logic [1:0] act;
    int idx;
    int pin;

    always_comb
    begin
        state_next = state_reg;
        ev = '0;
        clr = '0;
        mw = '0;
        cfg = '0;
        act = '0;
        idx = 0;
        pin = 0;
        own = '0;
        match = '0;
        cap_hit = '0;
        pacc_inc = 1'b0;
        pacc_edge = 1'b0;
        wd_timeout = 1'b0;
        // three flop pin synchroniser, level moves when stages 2 and 3 agree
        state_next.s1 = PA_I;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < PIN_N; i++)
        begin
            if (state_reg.s2[i] == state_reg.s3[i])
                state_next.lvl[i] = state_reg.s3[i];
        end
        rise = ~state_reg.lvl & state_next.lvl;
        fall = state_reg.lvl & ~state_next.lvl;
        // RQ7 free running divider chain
        state_next.chain = state_reg.chain + CHAIN_W'(1);
        // RQ1 prescaler tap
        tick = low_ones(state_reg.chain,
                        presc_log2(state_reg.ctrl[CTRL_PRESC +: 2]));
        cnt_inc = state_reg.cnt + 16'h0001;
        // RQ20 one step per tick
        if (tick)
        begin
            state_next.cnt = cnt_inc;
            // RQ3 wrap and overflow
            if (state_reg.cnt == CNT_MAX)
                ev[FLG_OVF] = 1'b1;
        end
        // RQ13 edge selection on the four capture pins
        for (int k = 0; k <= CH_SHARED; k++)
        begin
            cfg = state_reg.edge_cfg[2*k +: 2];
            cap_hit[k] = (cfg[EDGE_RISE] & rise[k]) |
                (cfg[EDGE_FALL] & fall[k]);
        end
        cap_hit[CH_SHARED] = cap_hit[CH_SHARED] &
            state_reg.ctrl[CTRL_CH4_CAPT];
        // RQ19 capture the settled count
        for (int k = 0; k <= CH_SHARED; k++)
        begin
            if (cap_hit[k])
            begin
                state_next.ch[k] = state_reg.cnt;
                ev[k] = 1'b1;
            end
        end
        // RQ5 compare channels match on the new count
        for (int k = CH_SHARED; k < CH_N; k++)
        begin
            match[k] = tick && (cnt_inc == state_reg.ch[k]);
        end
        match[CH_SHARED] = match[CH_SHARED] &
            ~state_reg.ctrl[CTRL_CH4_CAPT];
        ev[CH_N-1:CH_SHARED] = ev[CH_N-1:CH_SHARED] | match[CH_N-1:CH_SHARED];
        // RQ16 channels two to five on pins six down to three
        for (int j = 0; j < 4; j++)
        begin
            idx = (j == 3) ? CH_SHARED : CH_OC1 + 1 + j;
            pin = PIN_TOP - 1 - j;
            act = state_reg.oc_act[2*j +: 2];
            if (j == 3 && state_reg.ctrl[CTRL_CH4_CAPT])
                act = OC_NONE;
            own[pin] = (act != OC_NONE);
            if (match[idx])
            begin
                case (act)
                    OC_TOGGLE: state_next.oc_lvl[pin] = ~state_reg.oc_lvl[pin];
                    OC_CLEAR: state_next.oc_lvl[pin] = 1'b0;
                    OC_SET: state_next.oc_lvl[pin] = 1'b1;
                    default: state_next.oc_lvl[pin] = state_reg.oc_lvl[pin];
                endcase
            end
        end
        // RQ17 channel one drives any masked upper pin, taking priority
        for (int p = PIN_OC_LOW; p <= PIN_TOP; p++)
        begin
            if (state_reg.oc1_ctl[p - PIN_OC_LOW])
            begin
                own[p] = 1'b1;
                if (match[CH_OC1])
                    state_next.oc_lvl[p] =
                        state_reg.oc1_ctl[p - PIN_OC_LOW + OC1_DATA];
            end
        end
        // RQ10 periodic interrupt at one of four chain taps
        if (low_ones(state_reg.chain,
                     RTI_BASE_LOG2 + int'(state_reg.ctrl[CTRL_RTI +: 2])))
            ev[FLG_RTI] = 1'b1;
        // RQ18 top pin feeds the pulse accumulator
        if (state_reg.ctrl[CTRL_PACC_EN])
        begin
            if (!state_reg.ctrl[CTRL_PACC_GATED])
            begin
                // RQ8 count selected edges
                pacc_edge = state_reg.ctrl[CTRL_PACC_POL] ?
                    rise[PIN_TOP] : fall[PIN_TOP];
                pacc_inc = pacc_edge;
            end
            else
            begin
                // RQ9 count chain ticks while level matches
                pacc_edge = state_reg.ctrl[CTRL_PACC_POL] ?
                    fall[PIN_TOP] : rise[PIN_TOP];
                pacc_inc = low_ones(state_reg.chain, PACC_GATE_LOG2) &&
                    (state_reg.lvl[PIN_TOP] == state_reg.ctrl[CTRL_PACC_POL]);
            end
        end
        ev[FLG_PACC_EDGE] = pacc_edge;
        if (pacc_inc)
        begin
            state_next.pacc = state_reg.pacc + 8'h01;
            if (state_reg.pacc == PACC_MAX)
                ev[FLG_PACC_OVF] = 1'b1;
        end
        // RQ11 watchdog on the chain tap
        wd_tick = low_ones(state_reg.chain, WD_DIV_LOG2);
        if (!state_reg.ctrl[CTRL_WD_EN])
            state_next.wd_cnt = '0;
        else if (wd_tick)
        begin
            if (state_reg.wd_cnt == WD_LAST)
            begin
                wd_timeout = 1'b1;
                state_next.wd_cnt = '0;
            end
            else
                state_next.wd_cnt = state_reg.wd_cnt + 4'h1;
        end
        // RQ12 reset pin pulse
        if (wd_timeout)
        begin
            state_next.rst_drv = 1'b1;
            state_next.rst_cnt = RST_CNT_LOAD;
        end
        else if (state_reg.rst_drv)
        begin
            if (state_reg.rst_cnt == 3'h0)
                state_next.rst_drv = 1'b0;
            else
                state_next.rst_cnt = state_reg.rst_cnt - 3'h1;
        end
        // wishbone: ack one cycle after request, write at the acked edge
        req = WB_CYC_I & WB_STB_I & ~state_reg.ack;
        wr = WB_CYC_I & WB_STB_I & state_reg.ack & WB_WE_I;
        state_next.ack = req;
        state_next.rdat = '0;
        if (req)
        begin
            if (WB_ADR_I == OFF_CTRL)
                state_next.rdat = 32'(state_reg.ctrl);
            else if (WB_ADR_I == OFF_COUNT)
                state_next.rdat = 32'(state_reg.cnt);
            else if (WB_ADR_I == OFF_EDGE)
                state_next.rdat = 32'(state_reg.edge_cfg);
            else if (WB_ADR_I == OFF_OC_ACT)
                state_next.rdat = 32'(state_reg.oc_act);
            else if (WB_ADR_I == OFF_OC1)
                state_next.rdat = 32'(state_reg.oc1_ctl);
            else if (WB_ADR_I == OFF_FLAGS)
                state_next.rdat = 32'(state_reg.flags);
            else if (WB_ADR_I == OFF_IRQ_EN)
                state_next.rdat = 32'(state_reg.irq_en);
            // RQ14 pin levels readable at all times
            else if (WB_ADR_I == OFF_PORT)
                state_next.rdat = 32'(state_reg.lvl);
            else if (WB_ADR_I == OFF_DIR)
                state_next.rdat = 32'(state_reg.dir);
            else if (WB_ADR_I == OFF_PACC)
                state_next.rdat = 32'(state_reg.pacc);
            else if (WB_ADR_I >= OFF_CHAN && WB_ADR_I <= OFF_CHAN_END)
                state_next.rdat = 32'(state_reg.ch[WB_ADR_I[4:2]]);
        end
        // RQ4 the count register has no write path
        if (wr)
        begin
            if (WB_ADR_I == OFF_CTRL)
            begin
                mw = wb_merge(32'(state_reg.ctrl), WB_DAT_I, WB_SEL_I);
                state_next.ctrl = mw[CTRL_W-1:0];
            end
            else if (WB_ADR_I == OFF_EDGE)
            begin
                mw = wb_merge(32'(state_reg.edge_cfg), WB_DAT_I, WB_SEL_I);
                state_next.edge_cfg = mw[7:0];
            end
            else if (WB_ADR_I == OFF_OC_ACT)
            begin
                mw = wb_merge(32'(state_reg.oc_act), WB_DAT_I, WB_SEL_I);
                state_next.oc_act = mw[7:0];
            end
            else if (WB_ADR_I == OFF_OC1)
            begin
                mw = wb_merge(32'(state_reg.oc1_ctl), WB_DAT_I, WB_SEL_I);
                state_next.oc1_ctl = mw[OC1_W-1:0];
            end
            else if (WB_ADR_I == OFF_FLAGS)
            begin
                mw = wb_merge(32'h0000_0000, WB_DAT_I, WB_SEL_I);
                clr = mw[FLG_W-1:0];
            end
            else if (WB_ADR_I == OFF_IRQ_EN)
            begin
                mw = wb_merge(32'(state_reg.irq_en), WB_DAT_I, WB_SEL_I);
                state_next.irq_en = mw[FLG_W-1:0];
            end
            else if (WB_ADR_I == OFF_PORT)
            begin
                mw = wb_merge(32'(state_reg.gp), WB_DAT_I, WB_SEL_I);
                state_next.gp = mw[PIN_N-1:0];
            end
            else if (WB_ADR_I == OFF_DIR)
            begin
                mw = wb_merge(32'(state_reg.dir), WB_DAT_I, WB_SEL_I);
                state_next.dir = mw[PIN_N-1:0];
            end
            else if (WB_ADR_I == OFF_PACC)
            begin
                mw = wb_merge(32'(state_reg.pacc), WB_DAT_I, WB_SEL_I);
                state_next.pacc = mw[7:0];
            end
            else if (WB_ADR_I == OFF_WDOG && WB_SEL_I[0])
            begin
                // RQ11 two step service sequence
                if (WB_DAT_I[7:0] == WD_KEY_ARM)
                    state_next.wd_st = WD_ARMED;
                else
                begin
                    if (WB_DAT_I[7:0] == WD_KEY_FIRE &&
                        state_reg.wd_st == WD_ARMED)
                        state_next.wd_cnt = '0;
                    state_next.wd_st = WD_IDLE;
                end
            end
            else if (WB_ADR_I >= OFF_CHAN && WB_ADR_I <= OFF_CHAN_END)
            begin
                if (WB_ADR_I[4:2] >= 3'(CH_OC1) ||
                    (WB_ADR_I[4:2] == 3'(CH_SHARED) &&
                     !state_reg.ctrl[CTRL_CH4_CAPT]))
                begin
                    mw = wb_merge(32'(state_reg.ch[WB_ADR_I[4:2]]),
                                  WB_DAT_I, WB_SEL_I);
                    state_next.ch[WB_ADR_I[4:2]] = mw[15:0];
                end
            end
        end
        // set wins over a same cycle clear
        state_next.flags = (state_reg.flags & ~clr) | ev;
        // RQ15 owned pins show the compare level, not the gpio latch
        for (int i = 0; i < PIN_N; i++)
        begin
            state_next.pa_out[i] = own[i] ? state_next.oc_lvl[i] :
                state_next.gp[i];
            state_next.pa_oe[i] = own[i] | state_next.dir[i];
        end
        if (state_next.ctrl[CTRL_PACC_EN] && !own[PIN_TOP])
            state_next.pa_oe[PIN_TOP] = 1'b0;
    end

    // RQ2 counter starts from zero, compares from all ones
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_reg <= '0;
            for (int k = CH_SHARED; k < CH_N; k++)
            begin
                state_reg.ch[k] <= CMP_RST;
            end
        end
        else
            state_reg <= state_next;
    end

    assign WB_DAT_O = state_reg.rdat;
    assign WB_ACK_O = state_reg.ack;
    assign PA_O = state_reg.pa_out;
    assign PA_OE_O = state_reg.pa_oe;
    assign RST_PIN_O = 1'b0;
    assign RST_PIN_OE_O = state_reg.rst_drv;
    // RQ6 one gated line per event
    assign IRQ_O = state_reg.flags & state_reg.irq_en;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);

    a_count_step: assert property (tick |=> //RQ20
        state_reg.cnt == 16'($past(state_reg.cnt) + 16'h0001))
        else $error("counter did not step on tick");
    a_count_hold: assert property (!tick |=> $stable(state_reg.cnt)) //RQ4
        else $error("counter moved without tick");
    a_wrap_flag: assert property ((tick && state_reg.cnt == CNT_MAX) //RQ3
        |=> state_reg.cnt == 16'h0000 && state_reg.flags[FLG_OVF])
        else $error("wrap did not clear count or set overflow");
    a_presc_one: assert property ( //RQ1
        state_reg.ctrl[CTRL_PRESC +: 2] == 2'h0 |-> tick)
        else $error("divide by one missed a tick");
    a_presc_four: assert property ( //RQ1
        (tick && state_reg.ctrl[CTRL_PRESC +: 2] == 2'h1) |=>
        (state_reg.ctrl[CTRL_PRESC +: 2] != 2'h1 || !tick)[*3])
        else $error("divide by four ticked early");
    a_capture_take: assert property (cap_hit[0] |=> //RQ13
        state_reg.ch[0] == $past(state_reg.cnt) && state_reg.flags[0])
        else $error("capture did not latch the count");
    a_wd_pulse: assert property ($rose(RST_PIN_OE_O) |-> //RQ12
        RST_PIN_OE_O[*4] ##1 !RST_PIN_OE_O)
        else $error("reset pin pulse length wrong");
    a_wd_fire: assert property (wd_timeout |=> RST_PIN_OE_O) //RQ11
        else $error("timeout did not drive reset pin");
    a_pacc_event: assert property ( //RQ8
        (pacc_inc && !(wr && WB_ADR_I == OFF_PACC)) |=>
        state_reg.pacc == 8'($past(state_reg.pacc) + 8'h01))
        else $error("accumulator missed a count");
    a_port_read: assert property ((req && WB_ADR_I == OFF_PORT) |=> //RQ14
        WB_DAT_O[PIN_N-1:0] == $past(state_reg.lvl) && WB_ACK_O)
        else $error("port read wrong level");
    a_ovf_irq: assert property ((ev[FLG_OVF] && state_reg.irq_en[FLG_OVF] //RQ6
        && state_next.irq_en[FLG_OVF]) |=> IRQ_O[FLG_OVF])
        else $error("overflow interrupt not raised");
    a_rti_flag: assert property (ev[FLG_RTI] |=> //RQ10
        state_reg.flags[FLG_RTI])
        else $error("periodic flag not set");

    c_wrap: cover property (tick && state_reg.cnt == CNT_MAX);
    c_capture: cover property (cap_hit[0]);
    c_timeout: cover property (wd_timeout);
    c_pacc: cover property (pacc_inc);
endmodule : frt_timer

// File: frt_pins.sv
// frt_pins: port a pins and open drain reset line seen from outside.
// assumes the bench supplies the external pin levels.
`timescale 1ns/100ps
module frt_pins (
    // drive from the block
    input wire logic [7:0] pa_drv_i,
    input wire logic [7:0] pa_oe_i,
    input wire logic rst_drv_i,
    input wire logic rst_oe_i,
    // external levels
    input wire logic [7:0] ext_i,
    // resolved wires
    output logic [7:0] pin_o,
    output logic rst_pin_o
);
    // driven pins follow the block, the rest the outside world
    assign pin_o = (pa_drv_i & pa_oe_i) | (ext_i & ~pa_oe_i);
    // released reset line is pulled up
    assign rst_pin_o = rst_oe_i ? rst_drv_i : 1'b1;
endmodule : frt_pins

// File: tb_free_running_timer_chain.sv
// tb_free_running_timer_chain: self-checking bench of the timer block.
// assumes frt_pkg, frt_timer and the frt_pins partner model.
`timescale 1ns/100ps
module tb_free_running_timer_chain;
import frt_pkg::*;
typedef struct {
    logic [31:0] b;
    logic [31:0] m;
    logic [31:0] lo;
    logic [31:0] hi;
} frt_note_s;
logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
logic ack, rst_oe, rst_drv, rst_pin;
logic [11:0] irq;
logic [7:0] adr = 8'h00, ext = 8'h00, pa_i, pa_o, pa_oe;
logic [3:0] sel = 4'h0;
logic [31:0] dat = 32'h0000_0000, dat_o, rd, a, v;
frt_note_s q[$];
frt_note_s n;
int bad_count = 0, checks_done = 0, cycles = 0, k, div;
initial forever #5 clk = ~clk;
frt_timer #(.WD_DIV_LOG2(4), .RTI_BASE_LOG2(3), .WD_TIMEOUT_TICKS(2)) i_dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PA_I(pa_i), .PA_O(pa_o),
    .PA_OE_O(pa_oe), .RST_PIN_O(rst_drv), .RST_PIN_OE_O(rst_oe), .IRQ_O(irq));
frt_pins i_pins (.pa_drv_i(pa_o), .pa_oe_i(pa_oe), .rst_drv_i(rst_drv),
    .rst_oe_i(rst_oe), .ext_i(ext), .pin_o(pa_i), .rst_pin_o(rst_pin));
task automatic mism(input logic [31:0] g, input logic [31:0] e);
    $display("wrong value at %0t: got %h expected %h", $time, g, e);
    bad_count++;
endtask : mism
task automatic results;
    if (bad_count == 0 && checks_done > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask : results
task automatic note(input logic [31:0] b, m, lo, hi);
    q.push_back('{b, m, lo, hi});
endtask : note
task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                  output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
endtask : wb
// read results checked against the oldest note
always @(posedge clk)
begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
        bad_count++;
        results();
    end
    if (cyc && ack === 1'b1 && we === 1'b0 && q.size() > 0)
    begin
        n = q.pop_front();
        v = (dat_o - n.b) & n.m;
        checks_done++;
        if (!((v >= n.lo) === 1'b1 && (v <= n.hi) === 1'b1))
            mism(v, n.lo);
    end
end
initial
begin
    void'($urandom(32'h3c9e8f71));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    note(0, 32'hffff, 0, 16); wb(0, OFF_COUNT, 0, rd);
    note(0, 32'h100, 0, 0); wb(0, OFF_FLAGS, 0, rd);
    wb(1, OFF_IRQ_EN, 32'h100, rd);
    while (cycles < 65600) @(posedge clk);
    note(0, 32'hffff, 40, 90); wb(0, OFF_COUNT, 0, rd);
    note(0, 32'h100, 32'h100, 32'h100); wb(0, OFF_FLAGS, 0, rd);
    checks_done++;
    if (irq !== 12'h100) mism(32'(irq), 32'h100);
    // each prescale code, with a count write that must be ignored
    for (k = 0; k < 4; k++)
    begin
        div = (k == 0) ? 1 : (2 << k);
        wb(1, OFF_CTRL, k, rd);
        note(0, 32'hffff_0000, 0, 0); wb(0, OFF_COUNT, 0, a);
        wb(1, OFF_COUNT, 0, rd);
        repeat (64) @(posedge clk);
        note(a, 32'hffff, 64 / div, 80 / div + 1);
        wb(0, OFF_COUNT, 0, rd);
    end
    ext <= 8'($urandom());
    repeat (6) @(posedge clk);
    note(0, 32'hff, ext, ext); wb(0, OFF_PORT, 0, rd);
    ext <= 8'h00;
    wb(1, OFF_EDGE, 32'h09, rd);
    repeat (6) @(posedge clk);
    wb(1, OFF_FLAGS, 32'hfff, rd);
    ext <= 8'h03;
    repeat (6) @(posedge clk);
    note(0, 3, 1, 1); wb(0, OFF_FLAGS, 0, rd);
    // pin six owned by compare two ignores its gpio one, pin five does not
    wb(1, OFF_DIR, 32'h60, rd);
    wb(1, OFF_PORT, 32'h60, rd);
    wb(1, OFF_OC_ACT, 32'h03, rd);
    repeat (6) @(posedge clk);
    note(0, 32'h60, 32'h20, 32'h20); wb(0, OFF_PORT, 0, rd);
    wb(1, OFF_PACC, 0, rd);
    wb(1, OFF_CTRL, 32'h50, rd);
    repeat (10)
    begin
        ext <= ext ^ 8'h80;
        repeat (6) @(posedge clk);
    end
    note(0, 32'hff, 5, 5); wb(0, OFF_PACC, 0, rd);
    wb(1, OFF_CTRL, 32'h70, rd);
    wb(1, OFF_PACC, 0, rd);
    ext <= 8'h80;
    repeat (640) @(posedge clk);
    note(0, 32'hff, 9, 11); wb(0, OFF_PACC, 0, rd);
    wb(1, OFF_CTRL, 32'h100, rd);
    k = 0;
    while (rst_pin !== 1'b0 && k < 200)
    begin
        @(posedge clk);
        k++;
    end
    checks_done += 3;
    if (k < 16 || k > 64) mism(k, 32);
    repeat (3) @(posedge clk);
    if (rst_pin !== 1'b0) mism(rst_pin, 0);
    @(posedge clk);
    if (rst_pin !== 1'b1) mism(rst_pin, 1);
    results();
end
endmodule : tb_free_running_timer_chain
